// File: rtl/cpo_pkg.sv
/*
 constants for the call-progress pulse output block: register indices, field positions,
 reset values and the pulse period count. assumes a 100 MHz system clock.
*/
package cpo_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_RX_ATTEN = 8'h14;
  localparam logic [7:0] IDX_TX_ATTEN = 8'h15;
  // control field positions
  localparam int CTL_PULSE_EN_BIT = 0;
  localparam int CTL_INT_PIN_EN_BIT = 1;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_MODE_MSB = 5;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h02;
  localparam logic [7:0] RST_ATTEN = 8'h00;
  // output mode codes
  localparam logic [1:0] MODE_DELTA_SIGMA = 2'h0;
  localparam logic [1:0] MODE_RETURN_ZERO = 2'h1;
  localparam logic [1:0] MODE_BALANCED = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  // pulse timing
  localparam int CLK_HZ = 100_000_000;
  localparam int PULSE_HZ = 32_000;
  localparam int PERIOD_CYC_INT = CLK_HZ / PULSE_HZ;
  localparam logic [11:0] PERIOD_CYC = PERIOD_CYC_INT[11:0];
  localparam logic [11:0] PERIOD_HALF = PERIOD_CYC_INT[12:1];
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cpo_pkg

// File: rtl/cpo_top.sv
/*
 call-progress pulse output: mixes scaled receive and transmit samples and drives the
 analog monitor pin as delta-sigma, return-to-zero or balanced pulse stream.
 assumes samples and frame_sync are synchronous to CLK, an AXI4-Lite master on the bus.
*/
// Local design decision: register access over AXI4-Lite.
// Notes on behaviour
// - Receive and transmit paths are each scaled linearly by their own attenuation register.
// - An attenuation value of zero fully mutes its path in the monitor output.
// - Attenuation affects only the monitor output; line samples pass through untouched.
// - The mode field at bits 5:4 selects delta-sigma, 32 kHz return-to-zero or balanced 32 kHz output.
`timescale 1ns/10ps
module cpo_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic FRAME_SYNC,
  input wire logic signed [15:0] RX_SAMPLE,
  input wire logic signed [15:0] TX_SAMPLE,
  input wire logic INT_REQ,
  output logic signed [15:0] RX_LINE_OUT,
  output logic signed [15:0] TX_LINE_OUT,
  output logic ANALOG_MONITOR_PIN
);
  logic [7:0] ctl_q, ctl_d, rx_att_q, rx_att_d, tx_att_q, tx_att_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] widx, ridx;
  logic wr_hs, rd_hs;
  logic fs_prev_q, fs_rise;
  logic signed [15:0] mix_q, mix_d, rx_line_q, tx_line_q;
  logic signed [24:0] rx_prod, tx_prod;
  logic signed [25:0] mix_sum;
  logic [15:0] level;
  logic [27:0] duty_prod;
  logic [11:0] duty_q, duty_d, cnt_q, cnt_d, half_duty;
  logic [16:0] acc_q, acc_d;
  logic pin_q, pin_d, wave;
  logic pulse_en, int_pin_en;
  logic [1:0] mode;

  assign widx = S_AXI_AWADDR[9:2];
  assign ridx = S_AXI_ARADDR[9:2];
  assign wr_hs = awready_q && wready_q;
  assign rd_hs = arready_q && S_AXI_ARVALID;
  assign pulse_en = ctl_q[cpo_pkg::CTL_PULSE_EN_BIT];
  assign int_pin_en = ctl_q[cpo_pkg::CTL_INT_PIN_EN_BIT];
  assign mode = ctl_q[cpo_pkg::CTL_MODE_MSB:cpo_pkg::CTL_MODE_LSB];
  assign fs_rise = FRAME_SYNC && !fs_prev_q;

  // bus slave: take address and data together, answer one cycle later
  always_comb begin
    awready_d = 1'b0;
    wready_d = 1'b0;
    bvalid_d = bvalid_q && !S_AXI_BREADY;
    bresp_d = bresp_q;
    ctl_d = ctl_q;
    rx_att_d = rx_att_q;
    tx_att_d = tx_att_q;
    arready_d = 1'b0;
    rvalid_d = rvalid_q && !S_AXI_RREADY;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (S_AXI_AWVALID && S_AXI_WVALID && !wr_hs && !bvalid_q) begin
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
    if (wr_hs) begin
      bvalid_d = 1'b1;
      bresp_d = cpo_pkg::RESP_OKAY;
      unique case (widx)
        cpo_pkg::IDX_CONTROL: if (S_AXI_WSTRB[0]) ctl_d = S_AXI_WDATA[7:0] & 8'h33;
        cpo_pkg::IDX_RX_ATTEN: if (S_AXI_WSTRB[0]) rx_att_d = S_AXI_WDATA[7:0];
        cpo_pkg::IDX_TX_ATTEN: if (S_AXI_WSTRB[0]) tx_att_d = S_AXI_WDATA[7:0];
        cpo_pkg::IDX_STATUS: bresp_d = cpo_pkg::RESP_OKAY;
        default: bresp_d = cpo_pkg::RESP_SLVERR;
      endcase
    end
    if (S_AXI_ARVALID && !arready_q && !rvalid_q) begin
      arready_d = 1'b1;
    end
    if (rd_hs) begin
      rvalid_d = 1'b1;
      rresp_d = cpo_pkg::RESP_OKAY;
      unique case (ridx)
        cpo_pkg::IDX_CONTROL: rdata_d = {24'h000000, ctl_q};
        cpo_pkg::IDX_RX_ATTEN: rdata_d = {24'h000000, rx_att_q};
        cpo_pkg::IDX_TX_ATTEN: rdata_d = {24'h000000, tx_att_q};
        cpo_pkg::IDX_STATUS: rdata_d = {15'h0000, pin_q, mix_q};
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = cpo_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // bus and register flops
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= cpo_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= cpo_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
      ctl_q <= cpo_pkg::RST_CONTROL;
      rx_att_q <= cpo_pkg::RST_ATTEN;
      tx_att_q <= cpo_pkg::RST_ATTEN;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ctl_q <= ctl_d;
      rx_att_q <= rx_att_d;
      tx_att_q <= tx_att_d;
    end
  end

  // linear scaling and mixing, a zero attenuation gives a zero product
  always_comb begin
    rx_prod = RX_SAMPLE * $signed({1'b0, rx_att_q});
    tx_prod = TX_SAMPLE * $signed({1'b0, tx_att_q});
    mix_sum = 26'(rx_prod) + 26'(tx_prod);
    mix_d = fs_rise ? mix_sum[24:9] : mix_q;
    level = mix_q ^ 16'h8000; // offset binary
    duty_prod = level * cpo_pkg::PERIOD_CYC;
    duty_d = (cnt_q == 12'h000) ? duty_prod[27:16] : duty_q;
    half_duty = {1'b0, duty_q[11:1]};
    cnt_d = (cnt_q == cpo_pkg::PERIOD_CYC - 12'h001) ? 12'h000 : cnt_q + 12'h001;
    acc_d = {1'b0, acc_q[15:0]} + {1'b0, level};
  end

  // mode selection and pin routing
  always_comb begin
    unique case (mode)
      cpo_pkg::MODE_DELTA_SIGMA: wave = acc_q[16];
      cpo_pkg::MODE_RETURN_ZERO: wave = cnt_q < duty_q;
      cpo_pkg::MODE_BALANCED: wave = (cnt_q + half_duty >= cpo_pkg::PERIOD_HALF) &&
                                     (cnt_q < cpo_pkg::PERIOD_HALF + half_duty);
      cpo_pkg::MODE_RESERVED: wave = 1'b0;
    endcase
    if (int_pin_en) pin_d = INT_REQ;
    else if (pulse_en) pin_d = wave;
    else pin_d = 1'b0;
  end

  // datapath flops, line samples pass unscaled
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fs_prev_q <= 1'b0;
      mix_q <= 16'sh0000;
      duty_q <= 12'h000;
      cnt_q <= 12'h000;
      acc_q <= 17'h00000;
      pin_q <= 1'b0;
      rx_line_q <= 16'sh0000;
      tx_line_q <= 16'sh0000;
    end else begin
      fs_prev_q <= FRAME_SYNC;
      mix_q <= mix_d;
      duty_q <= duty_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      pin_q <= pin_d;
      rx_line_q <= RX_SAMPLE;
      tx_line_q <= TX_SAMPLE;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;
  assign RX_LINE_OUT = rx_line_q;
  assign TX_LINE_OUT = tx_line_q;
  assign ANALOG_MONITOR_PIN = pin_q;

  // checks
  sequence s_frame_edge;
    FRAME_SYNC && !fs_prev_q;
  endsequence
  sequence s_both_muted;
    rx_att_q == 8'h00 && tx_att_q == 8'h00;
  endsequence
  a_mute_both: assert property (@(posedge CLK) disable iff (!RST_N)
    (s_frame_edge and s_both_muted) |=> mix_q == 16'sh0000)
    else $error("muted paths gave nonzero mix");
  a_line_untouched: assert property (@(posedge CLK) disable iff (!RST_N)
    $past(RST_N) |-> (RX_LINE_OUT == $past(RX_SAMPLE) && TX_LINE_OUT == $past(TX_SAMPLE)))
    else $error("line sample altered");
  a_mix_holds: assert property (@(posedge CLK) disable iff (!RST_N)
    !fs_rise |=> $stable(mix_q))
    else $error("mix changed without frame sync");
  a_reserved_low: assert property (@(posedge CLK) disable iff (!RST_N)
    (mode == cpo_pkg::MODE_RESERVED && !int_pin_en) |=> !ANALOG_MONITOR_PIN)
    else $error("reserved mode drove pin");
  a_int_route: assert property (@(posedge CLK) disable iff (!RST_N)
    int_pin_en |=> ANALOG_MONITOR_PIN == $past(INT_REQ))
    else $error("interrupt not routed to pin");
  a_period_wrap: assert property (@(posedge CLK) disable iff (!RST_N)
    cnt_q == cpo_pkg::PERIOD_CYC - 12'h001 |=> cnt_q == 12'h000 ##1 cnt_q == 12'h001)
    else $error("pulse period wrong");
endmodule : cpo_top

// File: test/cpo_speaker_model.sv
/* speaker driver model: counts pin high cycles over a window.
 assumes pin is synchronous to clk. */
`timescale 1ns/10ps
module cpo_speaker_model #(parameter int WIN = 6250) (
  input wire logic clk,
  input wire logic pin,
  input wire logic start,
  output logic done,
  output logic [15:0] count
);
  int n = 0;
  logic run = 1'b0;
  initial done = 1'b0;
  initial count = 16'h0;
  // transistor on time integrated over the window
  always @(posedge clk) begin
    done <= 1'b0;
    if (start) begin
      run <= 1'b1;
      n <= 0;
      count <= 16'h0;
    end else if (run) begin
      count <= count + 16'(pin);
      n <= n + 1;
      if (n == WIN - 1) begin
        run <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule : cpo_speaker_model

// File: test/call_progress_pwm_output_bench.sv
/* bench for cpo_top: registers, pin modes, scaled mix, line path.
 assumes cpo_pkg and the speaker model. */
`timescale 1ns/10ps
module call_progress_pwm_output_bench;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0;
  logic rr = 1'b0, fs = 1'b0, irq = 1'b0, go = 1'b0, awr, wr_, bv, arr, rv, pin, done;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd;
  logic signed [15:0] rxs = 16'h0, txs = 16'h0, rxo, txo, r, t;
  logic [1:0] bresp, rresp;
  logic [15:0] cnt;
  logic [7:0] ra, ta;
  logic [15:0] mode_cnt [4] = '{16'h0C35, 16'h0C34, 16'h0C34, 16'h0};
  logic [33:0] exp_q [$];
  int n_errors = 0, samples_checked = 0, cyc = 0, fs_cnt = 0;

  always #5 clk = ~clk;
  // frame sync every 125 us
  always @(posedge clk) begin
    fs_cnt <= (fs_cnt == 12499) ? 0 : fs_cnt + 1;
    fs <= (fs_cnt == 0);
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_errors++;
      final_report();
    end
  end

  cpo_top dut (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .FRAME_SYNC(fs),
    .RX_SAMPLE(rxs), .TX_SAMPLE(txs), .INT_REQ(irq), .RX_LINE_OUT(rxo), .TX_LINE_OUT(txo),
    .ANALOG_MONITOR_PIN(pin));
  cpo_speaker_model spk (.clk(clk), .pin(pin), .start(go), .done(done), .count(cnt));

  task check(input logic [33:0] seen, input logic [33:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task final_report;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
    exp_q.push_back({resp, 32'h0});
    awa <= {22'h0, idx, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    @(posedge clk);
    while (!(awr && wr_)) @(posedge clk);
    awv <= 1'b0;
    wv <= 1'b0;
    while (!bv) @(posedge clk);
    br <= 1'b0;
    @(posedge clk); // let an edge pass before the next request
  endtask : wr

  task rd_(input logic [7:0] idx, input logic [33:0] want);
    exp_q.push_back(want);
    ara <= {22'h0, idx, 2'h0};
    arv <= 1'b1;
    rr <= 1'b1;
    @(posedge clk);
    while (!arr) @(posedge clk);
    arv <= 1'b0;
    while (!rv) @(posedge clk);
    rr <= 1'b0;
    @(posedge clk); // let an edge pass before the next request
  endtask : rd_

  task meas(input logic [15:0] want);
    repeat (16) @(posedge clk);
    exp_q.push_back({18'h0, want});
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (!done) @(posedge clk);
  endtask : meas

  function logic [15:0] mixf(input logic signed [15:0] a, b, input logic [7:0] ga, gb);
    logic signed [25:0] p;
    p = a * $signed({1'b0, ga}) + b * $signed({1'b0, gb});
    return p[24:9];
  endfunction : mixf

  // results taken off the queue as they appear
  always @(posedge clk) begin
    if (bv && br) check({bresp, 32'h0}, exp_q.pop_front());
    if (rv && rr) check({rresp, rd}, exp_q.pop_front());
    if (done) check({18'h0, cnt}, exp_q.pop_front());
  end

  initial begin
    void'($urandom(32'hA8C8));
    // live samples while both attenuations are zero, so the mix must stay silent
    rxs <= 16'($urandom);
    txs <= 16'($urandom);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_(cpo_pkg::IDX_CONTROL, {26'h0, cpo_pkg::RST_CONTROL});
    rd_(cpo_pkg::IDX_RX_ATTEN, {26'h0, cpo_pkg::RST_ATTEN});
    rd_(cpo_pkg::IDX_TX_ATTEN, {26'h0, cpo_pkg::RST_ATTEN});
    rd_(8'h10, {cpo_pkg::RESP_SLVERR, 32'h0});
    wr(8'h10, 8'h5A, cpo_pkg::RESP_SLVERR);
    $display("test registers done");
    // interrupt level owns the pin while its enable is set
    irq <= 1'b1;
    meas(16'h186A);
    irq <= 1'b0;
    // each mode at mid level: zero attenuation gives level 0x8000
    for (int m = 0; m < 4; m++) begin
      wr(cpo_pkg::IDX_CONTROL, {2'h0, m[1:0], 4'h1}, cpo_pkg::RESP_OKAY);
      meas(mode_cnt[m]);
    end
    $display("test modes done");
    wr(cpo_pkg::IDX_CONTROL, 8'h00, cpo_pkg::RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      ra = (i == 0) ? 8'h00 : 8'($urandom);
      ta = (i == 1) ? 8'h00 : 8'($urandom);
      r = 16'($urandom);
      t = 16'($urandom);
      rxs <= r;
      txs <= t;
      wr(cpo_pkg::IDX_RX_ATTEN, ra, cpo_pkg::RESP_OKAY);
      wr(cpo_pkg::IDX_TX_ATTEN, ta, cpo_pkg::RESP_OKAY);
      rd_(cpo_pkg::IDX_TX_ATTEN, {26'h0, ta});
      check({18'h0, rxo}, {18'h0, r});
      check({18'h0, txo}, {18'h0, t});
      do @(posedge clk); while (!fs);
      repeat (3) @(posedge clk);
      rd_(cpo_pkg::IDX_STATUS, {18'h0, mixf(r, t, ra, ta)});
    end
    $display("test mix done");
    final_report();
  end
endmodule : call_progress_pwm_output_bench
